// [pcseq_pkg.sv]
package pcseq_pkg;
  // address map and vectors
  localparam logic [31:0] PCSEQ_RESET_VEC   = 32'h0000_8000;
  localparam logic [31:0] PCSEQ_PROG_BASE   = 32'h0000_8000;
  localparam logic [31:0] PCSEQ_IRQ_BASE    = 32'h0000_8004;
  localparam logic [31:0] PCSEQ_IRQ_STEP    = 32'h0000_0004;
  localparam logic [3:0]  PCSEQ_IRQ_LAST    = 4'he;
  localparam logic [31:0] PCSEQ_EXC_VEC     = 32'h0000_8080;
  localparam logic [31:0] PCSEQ_LSB_MASK    = 32'hffff_fffe;
  localparam logic [31:0] PCSEQ_INSN_LEN    = 32'h0000_0002;
  localparam logic [15:0] PCSEQ_STK_STEP    = 16'h0002;
  localparam logic [15:0] PCSEQ_SP_RESET    = 16'h0000;
  localparam int          PCSEQ_IE_BIT      = 7;
  localparam int          PCSEQ_HALF        = 16;

  // next-address operations
  typedef enum logic [3:0] {
    PCSEQ_ADVANCE, PCSEQ_FAR_JUMP, PCSEQ_FAR_CALL, PCSEQ_REG_JUMP,
    PCSEQ_REG_CALL, PCSEQ_REG_CALL_PSW, PCSEQ_REL12_BR, PCSEQ_REL12_CALL,
    PCSEQ_REL12_CALL_PSW, PCSEQ_REGREL_BR, PCSEQ_REGREL_CALL,
    PCSEQ_REGREL_CALL_PSW, PCSEQ_COND12, PCSEQ_COND8, PCSEQ_RET, PCSEQ_INTERRUPT_RETURN
  } pcseq_op_t;

  typedef struct packed {
    pcseq_op_t   op;
    logic [15:0] base;
    logic [15:0] src;
    logic [11:0] off12;
    logic [7:0]  off8;
    logic [23:0] a24;
    logic [2:0]  nb;
    logic        taken;
  } pcseq_cmd_t;

  typedef struct packed {
    logic        en;
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } pcseq_stk_t;
endpackage

// [pcseq_core.sv]
`timescale 1ns/10ps
`default_nettype none
module pcseq_core (
  input  wire logic                i_mclk,
  input  wire logic                i_rst_n,
  input  wire logic                i_wdt_rst,
  input  wire logic                i_cmd_valid,
  input  wire pcseq_pkg::pcseq_cmd_t i_cmd,
  output logic                     o_cmd_ready,
  input  wire logic                i_irq_req,
  input  wire logic [3:0]          i_irq_src,
  input  wire logic                i_exc_req,
  output logic                     o_irq_ack,
  input  wire logic [15:0]         i_psw,
  input  wire logic                i_sp_load,
  input  wire logic [15:0]         i_sp_value,
  output logic [15:0]              o_stack_pointer,
  output pcseq_pkg::pcseq_stk_t    o_stk,
  input  wire logic [15:0]         i_stk_rdata,
  output logic                     o_psw_restore_valid,
  output logic [15:0]              o_psw_restore,
  output logic [31:0]              o_pc,
  output logic                     o_fetch_fault,
  input  wire logic [31:0]         i_data_addr,
  output logic                     o_data_low,
  output logic                     o_data_prog
);
  typedef enum {
    PCSEQ_IDLE, PCSEQ_PUSH_LO, PCSEQ_PUSH_HI, PCSEQ_PUSH_PSW,
    PCSEQ_POP_PSW, PCSEQ_POP_HI, PCSEQ_POP_LO, PCSEQ_POP_END
  } pcseq_state_t;

  pcseq_state_t state, next_state;
  logic [31:0]  pc, next_pc;
  logic [31:0]  ret_addr, next_ret_addr;
  logic [15:0]  saved_psw, next_saved_psw;
  logic [15:0]  sp, next_sp;
  logic [15:0]  pop_hi, next_pop_hi;
  logic         with_psw, next_with_psw;
  logic         irq_ack, next_irq_ack;
  logic         fault, next_fault;
  logic         psw_valid, next_psw_valid;
  logic [15:0]  psw_rest, next_psw_rest;
  logic         data_low, data_prog;

  logic [31:0]  seq_pc;
  logic [31:0]  target;
  logic         irq_take;
  logic         exc_take;
  logic [31:0]  off12_x, off8_x, src_x, nb_x;

  // sign and zero extension of the operands
  assign off12_x = {{20{i_cmd.off12[11]}}, i_cmd.off12};
  assign off8_x  = {{24{i_cmd.off8[7]}}, i_cmd.off8};
  assign src_x   = {{16{i_cmd.src[15]}}, i_cmd.src};
  assign nb_x    = {29'h0000_0000, i_cmd.nb};
  assign seq_pc  = pc + nb_x;

  // gating: no interrupt or exception is taken unless enabled and idle
  assign exc_take = (state == PCSEQ_IDLE) && i_exc_req && i_psw[pcseq_pkg::PCSEQ_IE_BIT];
  assign irq_take = (state == PCSEQ_IDLE) && i_irq_req && !i_exc_req
                    && i_psw[pcseq_pkg::PCSEQ_IE_BIT] && (i_irq_src <= pcseq_pkg::PCSEQ_IRQ_LAST);
  assign o_cmd_ready = (state == PCSEQ_IDLE) && !exc_take && !irq_take && !i_wdt_rst;

  // target selection per operation
  always_comb begin
    case (i_cmd.op)
      pcseq_pkg::PCSEQ_FAR_JUMP, pcseq_pkg::PCSEQ_FAR_CALL:
        target = {8'h00, i_cmd.a24};
      pcseq_pkg::PCSEQ_REG_JUMP, pcseq_pkg::PCSEQ_REG_CALL, pcseq_pkg::PCSEQ_REG_CALL_PSW:
        target = {i_cmd.base, i_cmd.src};
      pcseq_pkg::PCSEQ_REL12_BR, pcseq_pkg::PCSEQ_REL12_CALL, pcseq_pkg::PCSEQ_REL12_CALL_PSW:
        target = pc + pcseq_pkg::PCSEQ_INSN_LEN + off12_x;
      pcseq_pkg::PCSEQ_REGREL_BR, pcseq_pkg::PCSEQ_REGREL_CALL, pcseq_pkg::PCSEQ_REGREL_CALL_PSW:
        target = pc + pcseq_pkg::PCSEQ_INSN_LEN + src_x;
      pcseq_pkg::PCSEQ_COND12:
        target = i_cmd.taken ? seq_pc + off12_x : seq_pc;
      pcseq_pkg::PCSEQ_COND8:
        target = i_cmd.taken ? seq_pc + off8_x : seq_pc;
      default:
        target = seq_pc;
    endcase
  end

  // sequencer: vectoring, command decode, stack walk
  always_comb begin
    next_state     = state;
    next_pc        = pc;
    next_ret_addr  = ret_addr;
    next_saved_psw = saved_psw;
    next_sp        = i_sp_load ? i_sp_value : sp;
    next_pop_hi    = pop_hi;
    next_with_psw  = with_psw;
    next_irq_ack   = 1'b0;
    next_fault     = 1'b0;
    next_psw_valid = 1'b0;
    next_psw_rest  = psw_rest;
    case (state)
      PCSEQ_IDLE: begin
        if (exc_take || irq_take) begin
          next_ret_addr  = pc;
          next_saved_psw = i_psw;
          next_with_psw  = 1'b1;
          next_irq_ack   = 1'b1;
          next_state     = PCSEQ_PUSH_LO;
          if (exc_take) begin
            next_pc = pcseq_pkg::PCSEQ_EXC_VEC;
          end else begin
            next_pc = pcseq_pkg::PCSEQ_IRQ_BASE
                      + pcseq_pkg::PCSEQ_IRQ_STEP * {28'h000_0000, i_irq_src};
          end
        end else if (i_cmd_valid) begin
          next_ret_addr  = seq_pc;
          next_saved_psw = i_psw;
          case (i_cmd.op)
            pcseq_pkg::PCSEQ_RET: begin
              next_with_psw = 1'b0;
              next_state    = PCSEQ_POP_HI;
            end
            pcseq_pkg::PCSEQ_INTERRUPT_RETURN: begin
              next_with_psw = 1'b1;
              next_state    = PCSEQ_POP_PSW;
            end
            default: begin
              // a target in the low region would fetch data: divert to exception
              if (target < pcseq_pkg::PCSEQ_PROG_BASE) begin
                next_pc    = pcseq_pkg::PCSEQ_EXC_VEC;
                next_fault = 1'b1;
              end else begin
                next_pc = target & pcseq_pkg::PCSEQ_LSB_MASK;
              end
              if (i_cmd.op == pcseq_pkg::PCSEQ_FAR_CALL || i_cmd.op == pcseq_pkg::PCSEQ_REG_CALL
                  || i_cmd.op == pcseq_pkg::PCSEQ_REL12_CALL
                  || i_cmd.op == pcseq_pkg::PCSEQ_REGREL_CALL) begin
                next_with_psw = 1'b0;
                next_state    = PCSEQ_PUSH_LO;
              end else if (i_cmd.op == pcseq_pkg::PCSEQ_REG_CALL_PSW
                  || i_cmd.op == pcseq_pkg::PCSEQ_REL12_CALL_PSW
                  || i_cmd.op == pcseq_pkg::PCSEQ_REGREL_CALL_PSW) begin
                next_with_psw = 1'b1;
                next_state    = PCSEQ_PUSH_LO;
              end
            end
          endcase
        end
      end
      PCSEQ_PUSH_LO: begin
        next_sp    = sp + pcseq_pkg::PCSEQ_STK_STEP;
        next_state = PCSEQ_PUSH_HI;
      end
      PCSEQ_PUSH_HI: begin
        next_sp    = sp + pcseq_pkg::PCSEQ_STK_STEP;
        next_state = with_psw ? PCSEQ_PUSH_PSW : PCSEQ_IDLE;
      end
      PCSEQ_PUSH_PSW: begin
        next_sp    = sp + pcseq_pkg::PCSEQ_STK_STEP;
        next_state = PCSEQ_IDLE;
      end
      PCSEQ_POP_PSW: begin
        next_sp    = sp - pcseq_pkg::PCSEQ_STK_STEP;
        next_state = PCSEQ_POP_HI;
      end
      PCSEQ_POP_HI: begin
        // ram answers one cycle after each read
        if (with_psw) begin
          next_psw_rest  = i_stk_rdata;
          next_psw_valid = 1'b1;
        end
        next_sp    = sp - pcseq_pkg::PCSEQ_STK_STEP;
        next_state = PCSEQ_POP_LO;
      end
      PCSEQ_POP_LO: begin
        next_pop_hi = i_stk_rdata;
        next_sp     = sp - pcseq_pkg::PCSEQ_STK_STEP;
        next_state  = PCSEQ_POP_END;
      end
      PCSEQ_POP_END: begin
        next_pc    = {pop_hi, i_stk_rdata} & pcseq_pkg::PCSEQ_LSB_MASK;
        next_state = PCSEQ_IDLE;
      end
      default: next_state = PCSEQ_IDLE;
    endcase
    // watchdog overrides next pc and state; sp, ack and fault still follow the case above
    if (i_wdt_rst) begin
      next_pc    = pcseq_pkg::PCSEQ_RESET_VEC;
      next_state = PCSEQ_IDLE;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state     <= PCSEQ_IDLE;
      pc        <= pcseq_pkg::PCSEQ_RESET_VEC;
      ret_addr  <= pcseq_pkg::PCSEQ_RESET_VEC;
      saved_psw <= 16'h0000;
      sp        <= pcseq_pkg::PCSEQ_SP_RESET;
      pop_hi    <= 16'h0000;
      with_psw  <= 1'b0;
      irq_ack   <= 1'b0;
      fault     <= 1'b0;
      psw_valid <= 1'b0;
      psw_rest  <= 16'h0000;
    end else begin
      state     <= next_state;
      pc        <= next_pc;
      ret_addr  <= next_ret_addr;
      saved_psw <= next_saved_psw;
      sp        <= next_sp;
      pop_hi    <= next_pop_hi;
      with_psw  <= next_with_psw;
      irq_ack   <= next_irq_ack;
      fault     <= next_fault;
      psw_valid <= next_psw_valid;
      psw_rest  <= next_psw_rest;
    end
  end

  // stack port is driven from registered state only
  always_comb begin
    o_stk.en    = (state != PCSEQ_IDLE) && (state != PCSEQ_POP_END);
    o_stk.we    = (state == PCSEQ_PUSH_LO) || (state == PCSEQ_PUSH_HI)
                  || (state == PCSEQ_PUSH_PSW);
    o_stk.addr  = o_stk.we ? sp : sp - pcseq_pkg::PCSEQ_STK_STEP;
    case (state)
      PCSEQ_PUSH_LO:  o_stk.wdata = ret_addr[pcseq_pkg::PCSEQ_HALF-1:0];
      PCSEQ_PUSH_HI:  o_stk.wdata = ret_addr[31:pcseq_pkg::PCSEQ_HALF];
      PCSEQ_PUSH_PSW: o_stk.wdata = saved_psw;
      default:        o_stk.wdata = 16'h0000;
    endcase
  end

  // data region decode, registered; both regions accept data access
  always_comb begin
    data_low  = i_data_addr < pcseq_pkg::PCSEQ_PROG_BASE;
    data_prog = !data_low;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_data_low  <= 1'b0;
      o_data_prog <= 1'b0;
    end else begin
      o_data_low  <= data_low;
      o_data_prog <= data_prog;
    end
  end

  assign o_pc                = pc;
  assign o_stack_pointer     = sp;
  assign o_irq_ack           = irq_ack;
  assign o_fetch_fault       = fault;
  assign o_psw_restore_valid = psw_valid;
  assign o_psw_restore       = psw_rest;

  // checks
  property p_lsb;
    @(posedge i_mclk) disable iff (!i_rst_n) o_pc[0] == 1'b0;
  endproperty
  a_lsb: assert property (p_lsb) else $error("pc bit zero set");
  property p_wdt;
    @(posedge i_mclk) disable iff (!i_rst_n) i_wdt_rst |=> o_pc == pcseq_pkg::PCSEQ_RESET_VEC;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog did not vector");
  property p_ie;
    @(posedge i_mclk) disable iff (!i_rst_n)
      !$past(i_psw[pcseq_pkg::PCSEQ_IE_BIT]) |-> !o_irq_ack;
  endproperty
  a_ie: assert property (p_ie) else $error("interrupt without enable");
  property p_vec;
    @(posedge i_mclk) disable iff (!i_rst_n)
      o_irq_ack && !$past(i_wdt_rst) |-> o_pc[31:8] == 24'h00_0080 && o_pc[1:0] == 2'b00;
  endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_fetch;
    @(posedge i_mclk) disable iff (!i_rst_n) o_pc >= 32'h0000_8000;
  endproperty
  a_fetch: assert property (p_fetch) else $error("pc in low region");
  // ack coincides with the first push state, so six bytes are in after three edges
  property p_push6;
    @(posedge i_mclk) disable iff (!i_rst_n)
      o_irq_ack && !i_wdt_rst ##1 !i_wdt_rst ##1 !i_wdt_rst
      |=> o_stack_pointer == $past(o_stack_pointer, 3) + 16'h0006;
  endproperty
  a_push6: assert property (p_push6) else $error("status push not six");
  property p_push4;
    @(posedge i_mclk) disable iff (!i_rst_n)
      state == PCSEQ_PUSH_LO && !with_psw && !i_wdt_rst ##1 !i_wdt_rst
      |=> state == PCSEQ_IDLE && o_stack_pointer == $past(o_stack_pointer, 2) + 16'h0004;
  endproperty
  a_push4: assert property (p_push4) else $error("plain push not four");
  logic fault_next_pc;
  assign fault_next_pc = target < pcseq_pkg::PCSEQ_PROG_BASE;
  property p_adv;
    @(posedge i_mclk) disable iff (!i_rst_n)
      o_cmd_ready && i_cmd_valid && i_cmd.op == pcseq_pkg::PCSEQ_ADVANCE && !fault_next_pc
      |=> o_pc == (($past(o_pc) + {29'h0, $past(i_cmd.nb)}) & 32'hffff_fffe);
  endproperty
  a_adv: assert property (p_adv) else $error("advance wrong");
  property p_ret;
    @(posedge i_mclk) disable iff (!i_rst_n)
      o_cmd_ready && i_cmd_valid && i_cmd.op == pcseq_pkg::PCSEQ_RET ##1 (!i_wdt_rst)[*3]
      |=> o_pc[15:0] == ($past(i_stk_rdata) & 16'hfffe);
  endproperty
  a_ret: assert property (p_ret) else $error("return not from stack");
  c_irq: cover property (@(posedge i_mclk) disable iff (!i_rst_n) o_irq_ack);
  c_interrupt_return: cover property (@(posedge i_mclk) disable iff (!i_rst_n) o_psw_restore_valid);
  c_fault: cover property (@(posedge i_mclk) disable iff (!i_rst_n) o_fetch_fault);
endmodule
`default_nettype wire

// [pcseq_stack_ram.sv]
`timescale 1ns/10ps
`default_nettype none
// behavioural stack ram standing on the far side of the sequencer
module pcseq_stack_ram (
  input  wire logic                  i_mclk,
  input  wire pcseq_pkg::pcseq_stk_t i_stk,
  output logic [15:0]                o_rdata
);
  logic [15:0] mem [0:255];

  initial o_rdata = 16'h5a5a;

  // one-cycle read latency; outside a read the data toggles so a late sample cannot pass
  always @(posedge i_mclk) begin
    if (i_stk.en && i_stk.we) begin
      mem[i_stk.addr[8:1]] <= i_stk.wdata;
    end
    if (i_stk.en && !i_stk.we) begin
      o_rdata <= mem[i_stk.addr[8:1]];
    end else begin
      o_rdata <= ~o_rdata;
    end
  end
endmodule
`default_nettype wire

// [pcseq_core_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module pcseq_core_tb_top;
  logic                  clk, rst_n, wdt, cvalid, irq, exc, spld, ack, flt, dlow, dprog, rdy, prv;
  pcseq_pkg::pcseq_cmd_t cmd;
  pcseq_pkg::pcseq_stk_t stk;
  logic [3:0]            src;
  logic [15:0]           processor_status_word, spv, rdata, sp, prest;
  logic [31:0]           pc, daddr, p;
  int                    fail_count, n_checks, acks;

  pcseq_core pcseq_core_inst (.i_mclk(clk), .i_rst_n(rst_n), .i_wdt_rst(wdt),
    .i_cmd_valid(cvalid), .i_cmd(cmd), .o_cmd_ready(rdy), .i_irq_req(irq), .i_irq_src(src),
    .i_exc_req(exc), .o_irq_ack(ack), .i_psw(processor_status_word), .i_sp_load(spld), .i_sp_value(spv),
    .o_stack_pointer(sp), .o_stk(stk), .i_stk_rdata(rdata), .o_psw_restore_valid(prv),
    .o_psw_restore(prest), .o_pc(pc), .o_fetch_fault(flt), .i_data_addr(daddr),
    .o_data_low(dlow), .o_data_prog(dprog));
  pcseq_stack_ram pcseq_stack_ram_inst (.i_mclk(clk), .i_stk(stk), .o_rdata(rdata));

  // clock at 40 MHz
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // pulse monitor, since acks last one cycle only
  always @(posedge clk) begin
    if (ack === 1'b1) acks <= acks + 1;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // bounded wait for the sequencer to go idle, sampled at the falling edge
  task automatic wait_idle();
    int k;
    for (k = 0; k < 20; k++) begin
      @(negedge clk);
      if (rdy === 1'b1) return;
    end
    check("ready", 32'h0, 32'h1);
  endtask

  task automatic run(input pcseq_pkg::pcseq_op_t op, input logic [23:0] a, input logic [15:0] b,
                     input logic [15:0] s, input logic [11:0] o12, input logic [7:0] o8,
                     input logic [2:0] n, input logic tk);
    @(posedge clk);
    cvalid <= 1'b1;
    cmd    <= '{op: op, base: b, src: s, off12: o12, off8: o8, a24: a, nb: n, taken: tk};
    do @(posedge clk); while (rdy !== 1'b1); // held until the core takes it
    cvalid <= 1'b0;
    wait_idle();
  endtask

  // request held until acknowledged, then dropped while the push keeps the core busy
  task automatic take_irq(input logic e, input logic [3:0] s);
    int k;
    @(posedge clk);
    irq <= !e;
    exc <= e;
    src <= s;
    for (k = 0; k < 10 && ack !== 1'b1; k++) @(negedge clk);
    check("ack", {31'h0, ack}, 32'h1);
    @(posedge clk);
    irq <= 1'b0;
    exc <= 1'b0;
    wait_idle();
  endtask

  task automatic t_jumps();
    run(pcseq_pkg::PCSEQ_FAR_JUMP, 24'h12_3457, 0, 0, 0, 0, 2, 1);
    check("pc", pc, 32'h0012_3456);
    run(pcseq_pkg::PCSEQ_ADVANCE, 0, 0, 0, 0, 0, 2, 1);
    check("pc", pc, 32'h0012_3458);
    run(pcseq_pkg::PCSEQ_REG_JUMP, 0, 16'h0001, 16'h2345, 0, 0, 2, 1);
    check("pc", pc, 32'h0001_2344);
    $display("test jumps done");
  endtask

  task automatic t_branches();
    p = pc;
    run(pcseq_pkg::PCSEQ_REL12_BR, 0, 0, 0, 12'h800, 0, 2, 1);
    check("pc", pc, p + 32'd2 - 32'd2048);
    p = pc;
    run(pcseq_pkg::PCSEQ_REGREL_BR, 0, 0, 16'h8000, 0, 0, 2, 1);
    check("pc", pc, p + 32'd2 - 32'd32768);
    p = pc;
    run(pcseq_pkg::PCSEQ_COND8, 0, 0, 0, 0, 8'h7f, 4, 1);
    check("pc", pc, (p + 32'd131) & 32'hffff_fffe);
    p = pc;
    run(pcseq_pkg::PCSEQ_COND12, 0, 0, 0, 12'h7fe, 0, 2, 1);
    check("pc", pc, p + 32'h800);
    p = pc;
    run(pcseq_pkg::PCSEQ_COND8, 0, 0, 0, 0, 8'h80, 2, 0);
    check("pc", pc, p + 32'd2);
    $display("test branches done");
  endtask

  task automatic t_map();
    run(pcseq_pkg::PCSEQ_FAR_JUMP, 24'h00_0100, 0, 0, 0, 0, 2, 1);
    check("pc", pc, 32'h0000_8080);
    check("fault", {31'h0, flt}, 32'h1);
    @(posedge clk) daddr <= 32'h0000_7ffe;
    repeat (2) @(posedge clk);
    @(negedge clk) check("decode", {30'h0, dlow, dprog}, 32'h2);
    @(posedge clk) daddr <= 32'h0000_8000;
    repeat (2) @(posedge clk);
    @(negedge clk) check("decode", {30'h0, dlow, dprog}, 32'h1);
    $display("test map done");
  endtask

  // pushes and pops walk the partner ram; words land at sp, sp+2, sp+4
  task automatic t_calls();
    @(posedge clk);
    spld <= 1'b1;
    spv  <= 16'h0040;
    processor_status_word  <= 16'h1234;
    @(posedge clk) spld <= 1'b0;
    run(pcseq_pkg::PCSEQ_FAR_JUMP, 24'h03_0000, 0, 0, 0, 0, 2, 1);
    run(pcseq_pkg::PCSEQ_REG_CALL_PSW, 0, 16'h0000, 16'h9000, 0, 0, 2, 1);
    check("pc", pc, 32'h0000_9000);
    check("sp", sp, 32'h0046);
    check("lo", pcseq_stack_ram_inst.mem[8'h20], 32'h0002);
    check("hi", pcseq_stack_ram_inst.mem[8'h21], 32'h0003);
    check("psw", pcseq_stack_ram_inst.mem[8'h22], 32'h1234);
    run(pcseq_pkg::PCSEQ_REL12_CALL, 0, 0, 0, 12'h010, 0, 2, 1);
    check("pc", pc, 32'h0000_9012);
    check("sp", sp, 32'h004a);
    check("lo", pcseq_stack_ram_inst.mem[8'h23], 32'h9002);
    check("hi", pcseq_stack_ram_inst.mem[8'h24], 32'h0000);
    run(pcseq_pkg::PCSEQ_RET, 0, 0, 0, 0, 0, 2, 1);
    check("pc", pc, 32'h0000_9002);
    check("sp", sp, 32'h0046);
    run(pcseq_pkg::PCSEQ_FAR_CALL, 24'h00_a000, 0, 0, 0, 0, 4, 1);
    check("pc", pc, 32'h0000_a000);
    run(pcseq_pkg::PCSEQ_RET, 0, 0, 0, 0, 0, 2, 1);
    check("pc", pc, 32'h0000_9006);
    run(pcseq_pkg::PCSEQ_INTERRUPT_RETURN, 0, 0, 0, 0, 0, 2, 1);
    check("pc", pc, 32'h0003_0002);
    check("psw", prest, 32'h1234);
    check("sp", sp, 32'h0040);
    $display("test calls done");
  endtask

  task automatic t_irq();
    int i;
    logic [3:0] s[3] = '{4'h3, 4'he, 4'h0};
    logic [31:0] v[3] = '{32'h0000_8010, 32'h0000_803c, 32'h0000_8080};
    p = pc;
    @(posedge clk);
    processor_status_word <= 16'h0000;
    irq <= 1'b1;
    src <= 4'h3;
    repeat (6) @(posedge clk);
    irq <= 1'b0;
    @(negedge clk) check("acks", acks, 0);
    check("pc", pc, p);
    @(posedge clk) processor_status_word <= 16'h0080;
    for (i = 0; i < 3; i++) begin
      take_irq(i == 2, s[i]);
      check("vector", pc, v[i]);
      check("sp", sp, 32'h0046);
      run(pcseq_pkg::PCSEQ_INTERRUPT_RETURN, 0, 0, 0, 0, 0, 2, 1);
      check("pc", pc, p);
      check("psw", prest, 32'h0080);
    end
    $display("test interrupts done");
  endtask

  task automatic t_wdt();
    @(posedge clk) wdt <= 1'b1;
    @(posedge clk) wdt <= 1'b0;
    @(negedge clk) check("pc", pc, 32'h0000_8000);
    $display("test watchdog done");
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // main sequence; all inputs defined at time zero
  initial begin
    {rst_n, wdt, cvalid, irq, exc, spld} = '0;
    cmd = '0;
    src = '0;
    processor_status_word = '0;
    spv = '0;
    daddr = '0;
    acks = 0;
    repeat (6) @(posedge clk);
    check("pc", pc, 32'h0000_8000);
    check("sp", sp, 32'h0000);
    rst_n <= 1'b1;
    t_jumps();
    t_branches();
    t_map();
    t_calls();
    t_irq();
    t_wdt();
    complete_run();
  end

  // hang guard, about thirty-five times the expected run
  initial begin
    #100000;
    fail_count++;
    complete_run();
  end
endmodule
`default_nettype wire
